/* pio_defines.svh */
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses in the i/o page)
`define PIO_OFS_VALUE_A  6'h00
`define PIO_OFS_VALUE_G  6'h06
`define PIO_OFS_DIR_A    6'h07
`define PIO_OFS_DIR_G    6'h0d
`define PIO_OFS_SER_CTL  6'h10

// ==========================================================
// field positions and reset values
`define PIO_SER_EN_BIT   6
`define PIO_SER_PORT     3
`define PIO_SER_IN_BIT   5
`define PIO_SER_OUT_BIT  6
`define PIO_SER_CLK_BIT  7
`define PIO_DIR_RESET    8'h00
`define PIO_VALUE_RESET  8'h00

`endif

/* pio_pkg.sv */
package pio_pkg;
   // ==========================================================
   // types
   typedef logic [7:0] pio_byte_t;
   typedef logic [5:0] pio_addr_t;
   typedef enum logic [1:0] {
      PIO_ACC_NONE  = 2'b00,
      PIO_ACC_VALUE = 2'b01,
      PIO_ACC_DIR   = 2'b10,
      PIO_ACC_OTHER = 2'b11
   } pio_acc_t;
endpackage

/* pio_pin_sync.sv */
`timescale 1ns/100ps
`include "pio_defines.svh"

// three-stage pin sampler; a change counts once stages two and three agree
module pio_pin_sync import pio_pkg::*; #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // pins
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinLevel
);
   logic [WIDTH-1:0] stg1_r, stg2_r, stg3_r, level_r;
   logic [WIDTH-1:0] stg1_nxt, stg2_nxt, stg3_nxt, level_nxt;

   initial begin
      if (WIDTH < 1) $error("pio_pin_sync: WIDTH must be at least 1");
   end

   // ==========================================================
   // next state
   always_comb begin
      stg1_nxt = pinIn;
      stg2_nxt = stg1_r;
      stg3_nxt = stg2_r;
      level_nxt = level_r;
      for (int i = 0; i < WIDTH; i++) begin
         if (stg2_r[i] == stg3_r[i]) begin
            level_nxt[i] = stg3_r[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stg1_r  <= '0;
         stg2_r  <= '0;
         stg3_r  <= '0;
         level_r <= '0;
      end else begin
         stg1_r  <= stg1_nxt;
         stg2_r  <= stg2_nxt;
         stg3_r  <= stg3_nxt;
         level_r <= level_nxt;
      end
   end

   assign pinLevel = level_r;
endmodule // pio_pin_sync

/* pio_ports.sv */
`timescale 1ns/100ps
`include "pio_defines.svh"

// Operation
// RL1: a pin drives out whenever its direction bit is one.
// RL2: a pin is an undriven input whenever its direction bit is zero.
// RL3: reset clears every direction register, so all pins start as inputs.
// RL4: direction registers are read/write; reads return the last written value.
// RL5: data write with direction zero updates the latch only.
// RL6: data write with direction one updates latch and shows it on the pin.
// RL7: data read returns sampled pin level where direction is zero.
// RL8: data read returns latch contents where direction is one.
// RL9: six ports are eight bits wide; the last port has two bits.
// RL10: serial enable hands fourth-port pins five, six, seven to serial in/out/clock.
// RL11: the takeover follows bit six of the serial control register.
// RL12: unused upper bits of the two-bit port read zero, writes ignored.
module pio_ports import pio_pkg::*; #(
   parameter int NPORTS  = 7,
   parameter int LASTW   = 2
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   // processor register access
   input  wire logic [5:0]              regAddr,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   input  wire logic [7:0]              regWdata,
   output logic      [7:0]              regRdata,
   // port pins, flattened, port a in the low byte
   input  wire logic [NPORTS*8-1:0]     pinIn,
   output logic      [NPORTS*8-1:0]     pinOut,
   output logic      [NPORTS*8-1:0]     pinOe_b,
   // serial interface side
   input  wire logic                    serialOutPin,
   input  wire logic                    serialClkOut,
   input  wire logic                    serialClkDrive,
   output logic                         serialInPin,
   output logic                         serialInterfaceEnable,
   output logic                         serialClkIn
);
   localparam int NB = NPORTS * 8;

   initial begin
      if (NPORTS != 7) $error("pio_ports: register map serves exactly seven ports");
      if (LASTW < 1 || LASTW > 8) $error("pio_ports: LASTW must be 1..8");
   end

   // ==========================================================
   // register state
   logic [NB-1:0] latch_r, latch_nxt;
   logic [NB-1:0] dir_r, dir_nxt;
   logic          serEn_r, serEn_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic [NB-1:0] pinOut_r, pinOut_nxt;
   logic [NB-1:0] oeB_r, oeB_nxt;
   logic          serIn_r, serIn_nxt;
   logic          serClk_r, serClk_nxt;
   logic [NB-1:0] pinLevel;
   logic [NB-1:0] implMask;
   pio_acc_t      acc;
   int            portIdx;

   // unused bits of the narrow port are held at zero
   genvar gi;
   generate
      for (gi = 0; gi < NB; gi++) begin : g_mask
         assign implMask[gi] = (gi < (NPORTS - 1) * 8 + LASTW); // see RL9 see RL12
      end
   endgenerate

   pio_pin_sync #(
      .WIDTH (NB)
   ) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .pinIn    (pinIn),
      .pinLevel (pinLevel)
   );

   // ==========================================================
   // address decode
   always_comb begin
      acc = PIO_ACC_NONE;
      portIdx = 0;
      if (regAddr <= `PIO_OFS_VALUE_G) begin
         acc = PIO_ACC_VALUE;
         portIdx = int'(regAddr - `PIO_OFS_VALUE_A);
      end else if (regAddr >= `PIO_OFS_DIR_A && regAddr <= `PIO_OFS_DIR_G) begin
         acc = PIO_ACC_DIR;
         portIdx = int'(regAddr - `PIO_OFS_DIR_A);
      end else if (regAddr == `PIO_OFS_SER_CTL) begin
         acc = PIO_ACC_OTHER;
      end
   end

   // ==========================================================
   // register writes and reads
   always_comb begin
      latch_nxt = latch_r;
      dir_nxt   = dir_r;
      serEn_nxt = serEn_r;
      rdata_nxt = rdata_r;
      if (regWrite) begin
         case (acc)
            PIO_ACC_VALUE: begin
               // latch always written, drive depends on direction
               latch_nxt[portIdx*8 +: 8] = regWdata & implMask[portIdx*8 +: 8]; // see RL5 see RL6 see RL12
            end
            PIO_ACC_DIR: begin
               dir_nxt[portIdx*8 +: 8] = regWdata & implMask[portIdx*8 +: 8]; // see RL4 see RL12
            end
            PIO_ACC_OTHER: begin
               serEn_nxt = regWdata[`PIO_SER_EN_BIT]; // see RL11
            end
            default: begin
            end
         endcase
      end
      if (regRead) begin
         case (acc)
            PIO_ACC_VALUE: begin
               rdata_nxt = ((dir_r[portIdx*8 +: 8] & latch_r[portIdx*8 +: 8]) // see RL8
                         | (~dir_r[portIdx*8 +: 8] & pinLevel[portIdx*8 +: 8])) // see RL7
                         & implMask[portIdx*8 +: 8]; // see RL12
            end
            PIO_ACC_DIR: begin
               rdata_nxt = dir_r[portIdx*8 +: 8]; // see RL4
            end
            PIO_ACC_OTHER: begin
               rdata_nxt = 8'h00;
               rdata_nxt[`PIO_SER_EN_BIT] = serEn_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // pin drive; registered so outputs come straight from flops
   localparam int SI = (`PIO_SER_PORT) * 8 + `PIO_SER_IN_BIT;
   localparam int SO = (`PIO_SER_PORT) * 8 + `PIO_SER_OUT_BIT;
   localparam int SC = (`PIO_SER_PORT) * 8 + `PIO_SER_CLK_BIT;

   always_comb begin
      pinOut_nxt = latch_nxt & implMask; // see RL6
      oeB_nxt    = ~(dir_nxt & implMask); // see RL1 see RL2
      serIn_nxt  = pinLevel[SI];
      serClk_nxt = pinLevel[SC];
      if (serEn_nxt) begin
         // serial pins ignore the port registers while enabled
         oeB_nxt[SI]    = 1'b1; // see RL10
         pinOut_nxt[SI] = 1'b0;
         oeB_nxt[SO]    = 1'b0; // see RL10
         pinOut_nxt[SO] = serialOutPin;
         oeB_nxt[SC]    = ~serialClkDrive; // see RL10
         pinOut_nxt[SC] = serialClkOut;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_r  <= '0;
         dir_r    <= '0; // see RL3
         serEn_r  <= 1'b0;
         rdata_r  <= 8'h00;
         pinOut_r <= '0;
         oeB_r    <= '1; // see RL3
         serIn_r  <= 1'b0;
         serClk_r <= 1'b0;
      end else begin
         latch_r  <= latch_nxt;
         dir_r    <= dir_nxt;
         serEn_r  <= serEn_nxt;
         rdata_r  <= rdata_nxt;
         pinOut_r <= pinOut_nxt;
         oeB_r    <= oeB_nxt;
         serIn_r  <= serIn_nxt;
         serClk_r <= serClk_nxt;
      end
   end

   assign regRdata              = rdata_r;
   assign pinOut                = pinOut_r;
   assign pinOe_b               = oeB_r;
   assign serialInPin           = serIn_r;
   assign serialClkIn           = serClk_r;
   assign serialInterfaceEnable = serEn_r;

   // ==========================================================
   // checks
   chk_dir_drive: assert property (@(posedge clk) disable iff (!rst_b) // see RL1
      (!serEn_r && !serEn_nxt) |=> (oeB_r[7:0] == ~$past(dir_nxt[7:0])))
      else $error("port a drive does not follow direction");
   chk_input_float: assert property (@(posedge clk) disable iff (!rst_b) // see RL2
      (dir_r[15:8] == 8'h00 && dir_nxt[15:8] == 8'h00) |=> oeB_r[15:8] == 8'hff)
      else $error("port b driven while input");
   chk_reset_dir: assert property (@(posedge clk) // see RL3
      $rose(rst_b) |-> (dir_r == '0 && oeB_r == '1))
      else $error("direction not clear after reset");
   chk_dir_readback: assert property (@(posedge clk) disable iff (!rst_b) // see RL4
      (regWrite && regAddr == `PIO_OFS_DIR_A + 6'h01) ##1 (regRead && regAddr == `PIO_OFS_DIR_A + 6'h01
      && !regWrite) |=> regRdata == $past(regWdata, 2))
      else $error("direction readback mismatch");
   chk_latch_only: assert property (@(posedge clk) disable iff (!rst_b) // see RL5
      (regWrite && regAddr == `PIO_OFS_VALUE_A && dir_r[7:0] == 8'h00 && dir_nxt[7:0] == 8'h00)
      |=> (oeB_r[7:0] == 8'hff && latch_r[7:0] == $past(regWdata)))
      else $error("input-mode write drove the pins");
   chk_write_out: assert property (@(posedge clk) disable iff (!rst_b) // see RL6
      (regWrite && regAddr == `PIO_OFS_VALUE_A + 6'h04 && dir_r[39:32] == 8'hff)
      |=> (pinOut[39:32] == $past(regWdata) && oeB_r[39:32] == 8'h00))
      else $error("output-mode write not presented on port e");
   chk_read_mix: assert property (@(posedge clk) disable iff (!rst_b) // see RL7 see RL8
      (regRead && !regWrite && regAddr == `PIO_OFS_VALUE_A + 6'h02)
      |=> regRdata == (($past(dir_r[23:16]) & $past(latch_r[23:16]))
                     | (~$past(dir_r[23:16]) & $past(pinLevel[23:16]))))
      else $error("port c read mixes pin and latch wrongly");
   chk_narrow_zero: assert property (@(posedge clk) disable iff (!rst_b) // see RL9 see RL12
      (dir_r[55:48 + LASTW] == '0 && latch_r[55:48 + LASTW] == '0))
      else $error("unused port g bits hold a one");
   chk_serial_take: assert property (@(posedge clk) disable iff (!rst_b) // see RL10 see RL11
      (serEn_r && $past(serEn_r) && $past(serEn_nxt)) |-> (oeB_r[SI] && !oeB_r[SO]))
      else $error("serial pins not taken over");

   // ==========================================================
   // pin drive per port; the serial port is left out while the serial block owns it
   genvar gp;
   generate
      for (gp = 0; gp < NPORTS; gp++) begin : g_drive_chk
         chk_port_drive: assert property (@(posedge clk) disable iff (!rst_b) // see RL1 see RL2
            (gp != `PIO_SER_PORT || !serEn_r)
            |-> oeB_r[gp*8 +: 8] == ~(dir_r[gp*8 +: 8] & implMask[gp*8 +: 8]))
            else $error("pin drive does not follow the direction register");
      end
   endgenerate

   // ==========================================================
   // register state holds between accesses
   chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b) // see RL4
      !regRead |=> $stable(regRdata))
      else $error("read data changed without a read");

   chk_dir_hold: assert property (@(posedge clk) disable iff (!rst_b) // see RL4
      !regWrite |=> $stable(dir_r))
      else $error("direction changed without a write");

   chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_b) // see RL5
      !regWrite |=> $stable(latch_r))
      else $error("latch changed without a write");

   // ==========================================================
   // writes land where they should
   chk_latch_write: assert property (@(posedge clk) disable iff (!rst_b) // see RL5
      (regWrite && regAddr == `PIO_OFS_VALUE_A + 6'h01) |=> latch_r[15:8] == $past(regWdata))
      else $error("port b latch not written");

   chk_latch_write_g: assert property (@(posedge clk) disable iff (!rst_b) // see RL12
      (regWrite && regAddr == `PIO_OFS_VALUE_G) |=> latch_r[55:48] == ($past(regWdata) & implMask[55:48]))
      else $error("port g latch kept an unused bit");

   chk_dir_write_d: assert property (@(posedge clk) disable iff (!rst_b) // see RL4
      (regWrite && regAddr == `PIO_OFS_DIR_A + 6'h03) |=> dir_r[31:24] == $past(regWdata))
      else $error("port d direction not written");

   chk_dir_write_g: assert property (@(posedge clk) disable iff (!rst_b) // see RL12
      (regWrite && regAddr == `PIO_OFS_DIR_G) |=> dir_r[55:48] == ($past(regWdata) & implMask[55:48]))
      else $error("port g direction kept an unused bit");

   // latch and pin value move together, so a later direction change shows the latch at once
   chk_drive_value: assert property (@(posedge clk) disable iff (!rst_b) // see RL6
      pinOut_r[7:0] == latch_r[7:0])
      else $error("port a pin value differs from its latch");

   // ==========================================================
   // reads
   chk_read_mix_d: assert property (@(posedge clk) disable iff (!rst_b) // see RL7 see RL8
      (regRead && !regWrite && regAddr == `PIO_OFS_VALUE_A + 6'h03)
      |=> regRdata == (($past(dir_r[31:24]) & $past(latch_r[31:24]))
                     | (~$past(dir_r[31:24]) & $past(pinLevel[31:24]))))
      else $error("port d read mixes pin and latch wrongly");

   chk_g_val_read: assert property (@(posedge clk) disable iff (!rst_b) // see RL12
      (regRead && regAddr == `PIO_OFS_VALUE_G) |=> (regRdata & ~implMask[55:48]) == 8'h00)
      else $error("port g value read shows an unused bit");

   chk_g_dir_read: assert property (@(posedge clk) disable iff (!rst_b) // see RL12
      (regRead && regAddr == `PIO_OFS_DIR_G) |=> (regRdata & ~implMask[55:48]) == 8'h00)
      else $error("port g direction read shows an unused bit");

   chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_b) // see RL9
      (regRead && (regAddr == 6'h0e || regAddr == 6'h0f)) |=> regRdata == 8'h00)
      else $error("unmapped address read not zero");

   // unused port g pads must never be driven, even with a stray write
   chk_g_unused_pins: assert property (@(posedge clk) disable iff (!rst_b) // see RL9
      ((~oeB_r[55:48] & ~implMask[55:48]) == 8'h00 && (pinOut_r[55:48] & ~implMask[55:48]) == 8'h00))
      else $error("unused port g pad driven");

   chk_reset_pins: assert property (@(posedge clk) // see RL3
      $rose(rst_b) |-> (pinOut_r == '0 && rdata_r == 8'h00))
      else $error("pin values or read data not clear after reset");

   // ==========================================================
   // serial takeover
   chk_serial_in_float: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
      serEn_r |-> (oeB_r[SI] && !pinOut_r[SI]))
      else $error("serial data-in pin driven");

   chk_serial_out_value: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
      serEn_nxt |=> pinOut_r[SO] == $past(serialOutPin))
      else $error("serial data-out pin wrong");

   chk_serial_clk_pin: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
      serEn_nxt |=> (oeB_r[SC] == !$past(serialClkDrive) && pinOut_r[SC] == $past(serialClkOut)))
      else $error("serial clock pin wrong");

   chk_serin_sample: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
      1'b1 |=> serialInPin == $past(pinLevel[SI]))
      else $error("serial data-in not taken from its pin");

   chk_serclk_sample: assert property (@(posedge clk) disable iff (!rst_b) // see RL10
      1'b1 |=> serialClkIn == $past(pinLevel[SC]))
      else $error("serial clock-in not taken from its pin");

   chk_serial_release: assert property (@(posedge clk) disable iff (!rst_b) // see RL11
      !serEn_nxt |=> oeB_r[SO] == ~$past(dir_nxt[SO]))
      else $error("data-out pin not handed back to the port");

   chk_ser_en_write: assert property (@(posedge clk) disable iff (!rst_b) // see RL11
      (regWrite && regAddr == `PIO_OFS_SER_CTL) |=> serEn_r == $past(regWdata[`PIO_SER_EN_BIT]))
      else $error("serial enable not written");

   chk_ser_ctl_read: assert property (@(posedge clk) disable iff (!rst_b) // see RL11
      (regRead && regAddr == `PIO_OFS_SER_CTL) |=> regRdata == {1'b0, $past(serEn_r), 6'h00})
      else $error("serial control read wrong");

   cov_serial_on: cover property (@(posedge clk) disable iff (!rst_b) $rose(serEn_r));
   cov_out_write: cover property (@(posedge clk) disable iff (!rst_b) regWrite && acc == PIO_ACC_VALUE && dir_r != '0);
   cov_in_read:   cover property (@(posedge clk) disable iff (!rst_b) regRead && acc == PIO_ACC_VALUE);
   cov_serial_off: cover property (@(posedge clk) disable iff (!rst_b) $fell(serEn_r));
   cov_g_write:   cover property (@(posedge clk) disable iff (!rst_b) regWrite && regAddr == `PIO_OFS_DIR_G);
endmodule // pio_ports

/* pio_pin_world.sv */
`timescale 1ns/100ps

// ==========================================================
// external circuitry on the pads
// a released pad floats up through a pull-up, never to a stale value
module pio_pin_world (
   // design side
   input  wire logic [55:0] pinOut,
   input  wire logic [55:0] pinOe_b,
   // bench side
   input  wire logic [55:0] extVal,
   input  wire logic [55:0] extEn,
   output logic      [55:0] pinIn
);
   always_comb begin
      for (int i = 0; i < 56; i++) begin
         pinIn[i] = !pinOe_b[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
      end
   end
endmodule // pio_pin_world

/* pio_ports_test.sv */
`timescale 1ns/100ps

module pio_ports_test import pio_pkg::*;;
   // ==========================================================
   // signals
   logic        clk, rst_b, regWrite, regRead;
   pio_addr_t   regAddr;
   pio_byte_t   regWdata, regRdata, got, d, l;
   logic [55:0] pinIn, pinOut, pinOe_b, extVal, extEn;
   logic        serialOutPin, serialClkOut, serialClkDrive;
   logic        serialInPin, serialInterfaceEnable, serialClkIn;
   int          errCount, checksDone;
   int          dirM [7];
   int          latM [7];

   pio_ports u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe_b(pinOe_b),
      .serialOutPin(serialOutPin), .serialClkOut(serialClkOut), .serialClkDrive(serialClkDrive),
      .serialInPin(serialInPin), .serialInterfaceEnable(serialInterfaceEnable), .serialClkIn(serialClkIn));
   pio_pin_world u_world (.pinOut(pinOut), .pinOe_b(pinOe_b), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

   always #4 clk = ~clk;

   // ==========================================================
   // tasks
   task chkReg(input pio_byte_t g, input pio_byte_t e);
      checksDone++;
      if (g !== e) begin
         errCount++;
         $display("mismatch reg at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task chkPin(input pio_byte_t g, input pio_byte_t e);
      checksDone++;
      if (g !== e) begin
         errCount++;
         $display("mismatch pin at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input pio_addr_t a, input pio_byte_t v);
      @(negedge clk);
      regAddr = a;
      regWdata = v;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask
   task rd(input pio_addr_t a, output pio_byte_t v);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      @(negedge clk);
      v = regRdata;
   endtask
   function automatic pio_byte_t wm(int p);
      return (p == 6) ? 8'h03 : 8'hff;
   endfunction
   function automatic pio_byte_t padOf(int p);
      return (extVal[p*8 +: 8] & extEn[p*8 +: 8]) | ~extEn[p*8 +: 8];
   endfunction
   task tallyAndFinish;
      $display("comparisons %0d mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog, far beyond the several hundred cycles the tests need
   initial begin
      #160000;
      errCount++;
      tallyAndFinish();
   end

   // ==========================================================
   // tests
   initial begin
      clk = 1'b0; rst_b = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = 6'h00; regWdata = 8'h00;
      extVal = '0; extEn = '1; serialOutPin = 1'b0; serialClkOut = 1'b0; serialClkDrive = 1'b0;
      errCount = 0; checksDone = 0;
      void'($urandom(32'h69897048));
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      for (int p = 0; p < 7; p++) begin
         chkPin(pinOe_b[p*8 +: 8] | ~wm(p), 8'hff);
      end
      for (int a = 0; a < 14; a++) begin
         rd(6'(a), got);
         chkReg(got, 8'h00);
      end
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         extVal = 56'({$urandom, $urandom});
         extEn = 56'({$urandom, $urandom});
         for (int p = 0; p < 7; p++) begin
            d = 8'($urandom);
            l = 8'($urandom);
            if (r[0]) begin
               wr(6'(7 + p), d);
               wr(6'(p), l);
            end else begin
               wr(6'(7 + p), 8'h00);
               wr(6'(p), l);
               @(negedge clk);
               chkPin(pinOe_b[p*8 +: 8] & wm(p), wm(p));
               wr(6'(7 + p), d);
            end
            dirM[p] = d & wm(p);
            latM[p] = l & wm(p);
            @(negedge clk);
            chkPin(pinOe_b[p*8 +: 8] & wm(p), ~8'(dirM[p]) & wm(p));
            chkPin(pinOut[p*8 +: 8] & 8'(dirM[p]), 8'(latM[p] & dirM[p]));
            rd(6'(7 + p), got);
            chkReg(got, 8'(dirM[p]));
            repeat (6) @(negedge clk);
            rd(6'(p), got);
            chkReg(got, (8'(latM[p] & dirM[p]) | (padOf(p) & ~8'(dirM[p]))) & wm(p));
         end
      end
      rd(6'h0e, got);
      chkReg(got, 8'h00);
      $display("test random ports done");
      wr(6'h0a, 8'h00);
      extEn[31:29] = 3'b111;
      extVal[31:29] = 3'b101;
      serialOutPin = 1'b1;
      serialClkDrive = 1'b1;
      wr(6'h10, 8'h40);
      @(negedge clk);
      chkPin({7'h00, serialInterfaceEnable}, 8'h01);
      chkPin({5'h00, pinOe_b[31:29]}, 8'h01);
      chkPin({6'h00, pinOut[31:30]}, 8'h01);
      repeat (6) @(negedge clk);
      chkPin({7'h00, serialInPin}, 8'h01);
      serialClkDrive = 1'b0;
      extVal[29] = 1'b0;
      repeat (6) @(negedge clk);
      chkPin({6'h00, serialClkIn, serialInPin}, 8'h02);
      rd(6'h10, got);
      chkReg(got, 8'h40);
      wr(6'h10, 8'h00);
      @(negedge clk);
      chkPin({5'h00, pinOe_b[31:29]}, 8'h07);
      $display("test serial takeover done");
      wr(6'h07, 8'hff);
      rst_b = 1'b0;
      @(negedge clk);
      chkPin(pinOe_b[7:0], 8'hff);
      rst_b = 1'b1;
      rd(6'h07, got);
      chkReg(got, 8'h00);
      $display("test second reset done");
      tallyAndFinish();
   end
endmodule // pio_ports_test
